// ==== rtl/abs_link_consts.svh ====
// timing counts, character codes and field widths of the absolute position link
`ifndef ABS_LINK_CONSTS_SVH
`define ABS_LINK_CONSTS_SVH
`define CLK_HZ          20000000
`define BAUD_BPS        9600
`define BIT_CYCLES      ((`CLK_HZ + `BAUD_BPS / 2) / `BAUD_BPS)
`define PULSE_DIV       16
`define POS_W           36
`define UPPER_W         16
`define LOWER_W         20
`define CHAR_W          7
`define MSG_LEN         8
`define CH_P            7'h50
`define CH_A            7'h41
`define CH_M            7'h4d
`define CH_PLUS         7'h2b
`define CH_MINUS        7'h2d
`define CH_ZERO         7'h30
`define CH_CR           7'h0d
`define CH_SPACE        7'h20
`endif

// ==== rtl/abs_link_pkg.sv ====
// types used by the encoder end of the absolute position link and by the bench
package abs_link_pkg;
   typedef enum logic [2:0] {
      DEV_IDLE,
      DEV_LOAD,
      DEV_SERIAL,
      DEV_TRAIN,
      DEV_INCR
   } dev_state_e;
   typedef logic [6:0] char_t;
endpackage

// ==== rtl/abs_link_if.sv ====
// pulse output lines between the encoder output logic and the host controller
`timescale 1ns/1ns
interface abs_link_if;
   logic phase_a_divided_out;
   logic phase_b_divided_out;
   logic origin_marker_out;
   modport device_end (output phase_a_divided_out, output phase_b_divided_out, output origin_marker_out);
   modport host_end   (input phase_a_divided_out, input phase_b_divided_out, input origin_marker_out);
endinterface

// ==== rtl/abs_pos_out.sv ====
// encoder side: absolute position message, pulse train and incremental pulses
// What this block does
// - sends absolute position on phase A when sensor on
// - position is signed 36 bits, split 16 and 20
// - upper signed 16 bits sent first as message
// - lower 20 bits follow as a pulse train
// - then ordinary incremental A/B pulses
// - only the upper part goes out as characters
// - 9600 baud, start, 7 data, even parity, stop
// - message P, sign, five digits, carriage return
// - message repeats on every sensor-on command
// - position divided by divider setting first
// - lower 20 quotient bits form the train
// - only phase A toggles during the message
// - host has a serial receiver on phase A
// - host stores encoder coordinate of origin
// - host rebuilds upper times 2^20 plus lower
// - same rebuild in reverse direction mode
// - alarm message sent when sensor on drops
// - alarm message A, M, two digits, CR
// - host sends sensor off before power down
`timescale 1ns/1ns
`include "abs_link_consts.svh"
module abs_pos_out (
   input  wire logic               clk_i,
   input  wire logic               rst_b_i,
   input  wire logic               sensor_on_command_i,
   input  wire logic [`POS_W-1:0]  position_i,
   input  wire logic [15:0]        output_divider_setting_i,
   input  wire logic               direction_select_setting_i,
   input  wire logic               incr_step_i,
   input  wire logic               incr_dir_i,
   input  wire logic               origin_pulse_i,
   input  wire logic               alarm_active_i,
   input  wire logic [7:0]         alarm_code_i,
   output logic                    busy_o,
   abs_link_if.device_end          link
);
   //------------------------------------------------------------
   // helpers
   //------------------------------------------------------------
   // one decimal digit of a value as ascii, by repeated division
   function automatic abs_link_pkg::char_t dec_char(input logic [16:0] v, input int unsigned pos);
      logic [16:0] t;
      t = v;
      for (int i = 0; i < pos; i++) begin
         t = t / 17'd10;
      end
      dec_char = `CH_ZERO + abs_link_pkg::char_t'(t % 17'd10);
   endfunction

   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   typedef struct packed {
      abs_link_pkg::dev_state_e state;
      logic                     sens_q;
      logic [`MSG_LEN*7-1:0]    msg;
      logic [3:0]               char_idx;
      logic [3:0]               char_cnt;
      logic [3:0]               bit_idx;
      logic [15:0]              baud_cnt;
      logic [9:0]               frame;
      logic [`LOWER_W:0]        train_left;
      logic [4:0]               quad_div;
      logic [1:0]               quad_phase;
      logic                     a;
      logic                     b;
      logic                     z;
   } dev_s;

   dev_s cur;
   dev_s next_cur;
   logic signed [`POS_W-1:0] quot;
   logic signed [`UPPER_W-1:0] upper;
   logic [16:0] mag;
   logic incr_ff;
   logic step_ok;

   // scaled position: divide by divider setting, zero guarded
   always_comb begin
      if (output_divider_setting_i == 16'h0000) begin
         quot = $signed(position_i);
      end else begin
         quot = $signed(position_i) / $signed({20'h00000, output_divider_setting_i});
      end
      upper = quot[`POS_W-1 -: `UPPER_W];
      mag   = upper[15] ? 17'(-$signed({upper[15], upper})) : {1'b0, upper};
   end

   //------------------------------------------------------------
   // sequencer
   //------------------------------------------------------------
   // message, train and incremental phases in one process
   always_comb begin
      next_cur = cur;
      next_cur.sens_q = sensor_on_command_i;
      next_cur.z = origin_pulse_i;
      step_ok = 1'b0;
      incr_ff = incr_dir_i ^ direction_select_setting_i;
      unique case (cur.state)
         abs_link_pkg::DEV_IDLE: begin
            next_cur.a = 1'b1; // line idles mark
            if (sensor_on_command_i && !cur.sens_q) begin
               next_cur.state = abs_link_pkg::DEV_LOAD;
            end else if (!sensor_on_command_i && cur.sens_q && alarm_active_i) begin
               // alarm text in place of position
               next_cur.msg = {`CH_A, `CH_M, dec_char({9'h000, alarm_code_i}, 1),
                               dec_char({9'h000, alarm_code_i}, 0), `CH_CR, `CH_SPACE, `CH_SPACE, `CH_SPACE};
               next_cur.char_cnt = 4'd5;
               next_cur.char_idx = 4'd0;
               next_cur.bit_idx = 4'd10;
               next_cur.train_left = '0;
               next_cur.state = abs_link_pkg::DEV_SERIAL;
            end
         end
         abs_link_pkg::DEV_LOAD: begin
            // P, sign, five digits msf, cr
            next_cur.msg = {`CH_P, upper[15] ? `CH_MINUS : `CH_PLUS,
                            dec_char(mag, 4), dec_char(mag, 3), dec_char(mag, 2),
                            dec_char(mag, 1), dec_char(mag, 0), `CH_CR};
            next_cur.char_cnt = 4'd8;
            next_cur.char_idx = 4'd0;
            next_cur.bit_idx = 4'd10;
            next_cur.train_left = {1'b1, quot[`LOWER_W-1:0]};
            next_cur.state = abs_link_pkg::DEV_SERIAL;
         end
         abs_link_pkg::DEV_SERIAL: begin
            next_cur.b = 1'b0;
            if (cur.baud_cnt != 16'h0000) begin
               next_cur.baud_cnt = cur.baud_cnt - 16'd1;
            end else if (cur.bit_idx == 4'd10) begin
               if (cur.char_idx == cur.char_cnt) begin
                  next_cur.a = 1'b1;
                  // mark level a=1 b=0 is quarter 1, so the train starts without a false start edge
                  next_cur.quad_phase = 2'd1;
                  next_cur.state = cur.train_left[`LOWER_W] ? abs_link_pkg::DEV_TRAIN : abs_link_pkg::DEV_IDLE;
               end else begin
                  // start, 7 data lsb first, even parity, stop
                  next_cur.frame = {1'b1, ^cur.msg[`MSG_LEN*7-1 -: 7], cur.msg[`MSG_LEN*7-1 -: 7], 1'b0};
                  next_cur.msg = {cur.msg[`MSG_LEN*7-8:0], 7'h00};
                  next_cur.char_idx = cur.char_idx + 4'd1;
                  next_cur.bit_idx = 4'd0;
               end
            end else begin
               next_cur.a = cur.frame[cur.bit_idx];
               next_cur.bit_idx = cur.bit_idx + 4'd1;
               next_cur.baud_cnt = 16'(`BIT_CYCLES - 1);
            end
         end
         abs_link_pkg::DEV_TRAIN: begin
            // forward quadrature, one quarter step per count, same scale as incremental steps
            if (cur.quad_div != 5'd0) begin
               next_cur.quad_div = cur.quad_div - 5'd1;
            end else if (cur.train_left[`LOWER_W-1:0] == '0) begin
               next_cur.state = abs_link_pkg::DEV_INCR;
            end else begin
               next_cur.quad_div = 5'(`PULSE_DIV - 1);
               next_cur.quad_phase = cur.quad_phase + 2'd1;
               next_cur.train_left = cur.train_left - 21'd1;
            end
         end
         abs_link_pkg::DEV_INCR: begin
            if (!sensor_on_command_i) begin
               next_cur.state = abs_link_pkg::DEV_IDLE;
               if (alarm_active_i) begin
                  next_cur.sens_q = 1'b1; // re-enter idle as a falling edge
               end
            end else if (cur.quad_div != 5'd0) begin
               next_cur.quad_div = cur.quad_div - 5'd1;
            end else if (incr_step_i) begin
               step_ok = 1'b1;
               next_cur.quad_div = 5'(`PULSE_DIV - 1);
               next_cur.quad_phase = incr_ff ? cur.quad_phase - 2'd1 : cur.quad_phase + 2'd1;
            end
         end
      endcase
      if (cur.state == abs_link_pkg::DEV_TRAIN || cur.state == abs_link_pkg::DEV_INCR) begin
         // gray sequence on a and b
         next_cur.a = next_cur.quad_phase[1] ^ next_cur.quad_phase[0] ? 1'b1 : next_cur.quad_phase[1];
         next_cur.a = (next_cur.quad_phase == 2'd1) || (next_cur.quad_phase == 2'd2);
         next_cur.b = next_cur.quad_phase[1];
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur <= '{state: abs_link_pkg::DEV_IDLE, a: 1'b1, default: '0};
      end else begin
         cur <= next_cur;
      end
   end

   assign link.phase_a_divided_out = cur.a;
   assign link.phase_b_divided_out = cur.b;
   assign link.origin_marker_out   = cur.z;
   assign busy_o = (cur.state != abs_link_pkg::DEV_IDLE) && (cur.state != abs_link_pkg::DEV_INCR);
endmodule

// ==== rtl/abs_pos_host.sv ====
// host side: serial receiver on phase A, quadrature counter, position rebuild
`timescale 1ns/1ns
`include "abs_link_consts.svh"
module abs_pos_host (
   input  wire logic                      clk_i,
   input  wire logic                      rst_b_i,
   input  wire logic                      store_origin_i,
   abs_link_if.host_end                   link,
   output logic                           msg_valid_o,
   output logic                           alarm_valid_o,
   output logic [7:0]                     alarm_code_o,
   output logic signed [`UPPER_W-1:0]     upper_o,
   output logic signed [`POS_W-1:0]       encoder_pos_o,
   output logic signed [`POS_W-1:0]       machine_pos_o,
   output logic                           parity_err_o,
   output logic                           origin_seen_o
);
   typedef struct packed {
      logic [15:0]  baud_cnt;
      logic [3:0]   bit_idx;
      logic         busy;
      logic [8:0]   shreg;
      logic [3:0]   char_no;
      logic         neg;
      logic         is_alarm;
      logic [16:0]  acc;
      logic signed [`POS_W-1:0] count;
      logic signed [`POS_W-1:0] origin;
      logic signed [`UPPER_W-1:0] upper;
      logic [1:0]   ab_q;
      logic         msg_valid;
      logic         alarm_valid;
      logic [7:0]   alarm;
      logic         perr;
      logic         z_q;
   } host_s;

   host_s cur;
   host_s next_cur;
   logic [6:0] ch;
   logic [1:0] ab;

   always_comb begin
      next_cur = cur;
      ab = {link.phase_a_divided_out, link.phase_b_divided_out};
      next_cur.ab_q = ab;
      next_cur.z_q = link.origin_marker_out;
      next_cur.msg_valid = 1'b0;
      ch = cur.shreg[7:1]; // eight samples land in bits 8..1
      if (!cur.busy) begin
         if (!link.phase_a_divided_out && !link.phase_b_divided_out && cur.ab_q == 2'b10) begin
            next_cur.busy = 1'b1;
            next_cur.bit_idx = 4'd0;
            next_cur.baud_cnt = 16'(`BIT_CYCLES / 2 + `BIT_CYCLES - 1);
         end else if (cur.ab_q != ab) begin
            // quadrature decoding; a fall of a with b low is taken as a start bit above
            if ({cur.ab_q, ab} == 4'b0010 || {cur.ab_q, ab} == 4'b1011 || {cur.ab_q, ab} == 4'b1101 ||
                {cur.ab_q, ab} == 4'b0100) begin
               next_cur.count = cur.count + 36'sd1;
            end else begin
               next_cur.count = cur.count - 36'sd1;
            end
         end
      end else if (cur.baud_cnt != 16'h0000) begin
         next_cur.baud_cnt = cur.baud_cnt - 16'd1;
      end else if (cur.bit_idx != 4'd8) begin
         next_cur.shreg = {link.phase_a_divided_out, cur.shreg[8:1]};
         next_cur.bit_idx = cur.bit_idx + 4'd1;
         next_cur.baud_cnt = 16'(`BIT_CYCLES - 1);
      end else begin
         next_cur.busy = 1'b0;
         next_cur.perr = cur.perr | (^cur.shreg[8:1]);
         next_cur.char_no = cur.char_no + 4'd1;
         if (ch == `CH_P || ch == `CH_A) begin
            next_cur.char_no = 4'd1;
            next_cur.is_alarm = (ch == `CH_A);
            next_cur.acc = '0;
            next_cur.neg = 1'b0;
            next_cur.perr = ^cur.shreg[8:1];
         end else if (ch == `CH_MINUS) begin
            next_cur.neg = 1'b1;
         end else if (ch >= `CH_ZERO && ch <= 7'h39) begin
            next_cur.acc = 17'(cur.acc * 17'd10 + 17'(ch - `CH_ZERO));
         end else if (ch == `CH_CR) begin
            if (cur.is_alarm) begin
               next_cur.alarm = cur.acc[7:0];
               next_cur.alarm_valid = 1'b1;
            end else begin
               next_cur.upper = cur.neg ? 16'(-cur.acc) : cur.acc[15:0];
               next_cur.count = {next_cur.upper, 20'h00000};
               next_cur.msg_valid = 1'b1;
            end
         end
      end
      if (store_origin_i) begin
         next_cur.origin = cur.count;
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cur <= '{ab_q: 2'b10, default: '0};
      end else begin
         cur <= next_cur;
      end
   end

   assign msg_valid_o   = cur.msg_valid;
   assign alarm_valid_o = cur.alarm_valid;
   assign alarm_code_o  = cur.alarm;
   assign upper_o       = cur.upper;
   assign encoder_pos_o = cur.count;
   assign machine_pos_o = cur.count - cur.origin;
   assign parity_err_o  = cur.perr;
   assign origin_seen_o = cur.z_q;
endmodule

// ==== tb/abs_link_assertions.sv ====
// concurrent checks on the absolute position link lines
`timescale 1ns/1ns
`include "abs_link_consts.svh"
module abs_link_assertions (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic phase_a_divided_out,
   input wire logic phase_b_divided_out,
   input wire logic origin_marker_out
);
   localparam int BITC = `BIT_CYCLES;
   logic        a_q;
   logic        in_frame;
   logic        done;
   logic [11:0] cnt;
   logic [3:0]  bitn;
   logic [8:0]  shreg;

   // ----------------------------------------
   // frame tracker: start on a fall of a with b low
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         a_q <= 1'b1;
         in_frame <= 1'b0;
         done <= 1'b0;
         cnt <= '0;
         bitn <= '0;
         shreg <= '0;
      end else begin
         a_q <= phase_a_divided_out;
         done <= in_frame && bitn == 4'd9 && cnt == 12'(BITC / 2);
         if (!in_frame) begin
            if (a_q && !phase_a_divided_out && !phase_b_divided_out) begin
               in_frame <= 1'b1;
               cnt <= 12'd1;
               bitn <= '0;
            end
         end else if (cnt == 12'(BITC - 1)) begin
            cnt <= '0;
            bitn <= bitn + 4'd1;
         end else begin
            cnt <= cnt + 12'd1;
            if (cnt == 12'(BITC / 2)) begin
               shreg <= {phase_a_divided_out, shreg[8:1]}; // lsb first
               if (bitn == 4'd9) begin
                  in_frame <= 1'b0;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_reset_idle; $rose(rst_b_i) |-> phase_a_divided_out && !phase_b_divided_out && !origin_marker_out; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("lines not idle after reset");
   property p_b_quiet; in_frame |-> !phase_b_divided_out; endproperty
   a_b_quiet: assert property (p_b_quiet) else $error("phase b moved during a frame");
   property p_bit_edges; in_frame && $changed(phase_a_divided_out) |-> cnt == 12'd0; endproperty
   a_bit_edges: assert property (p_bit_edges) else $error("serial edge off the bit time");
   property p_start_low; in_frame && bitn == 4'd0 |-> !phase_a_divided_out; endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not held low");
   property p_stop_high; done |-> shreg[8]; endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit low");
   property p_even_parity; done |-> (^shreg[7:0]) == 1'b0; endproperty
   a_even_parity: assert property (p_even_parity) else $error("parity not even");
   property p_char_legal;
      done |-> shreg[6:0] inside {`CH_P, `CH_A, `CH_M, `CH_PLUS, `CH_MINUS, `CH_CR, [`CH_ZERO:7'h39]};
   endproperty
   a_char_legal: assert property (p_char_legal) else $error("character outside the message set");
   property p_quad_one_edge; !in_frame && $changed(phase_b_divided_out) |-> $stable(phase_a_divided_out); endproperty
   a_quad_one_edge: assert property (p_quad_one_edge) else $error("a and b changed together");
   property p_quad_spacing; !in_frame && $changed(phase_b_divided_out) |=> $stable(phase_b_divided_out) [*8]; endproperty
   a_quad_spacing: assert property (p_quad_spacing) else $error("phase b quarter too short");

   c_pos_char: cover property (done && shreg[6:0] == `CH_P);
   c_alarm_char: cover property (done && shreg[6:0] == `CH_A);
   c_quad: cover property (!in_frame && $changed(phase_b_divided_out));
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench joining the encoder output logic to the host receiver
`timescale 1ns/1ns
`include "abs_link_consts.svh"
module tb_top;
   localparam int BITC = `BIT_CYCLES;
   logic                       clk_i = 1'b0;
   logic                       rst_b_i = 1'b0;
   logic                       sensor_on = 1'b0;
   logic [35:0]                position = '0;
   logic [15:0]                divider = 16'h0001;
   logic                       dir_sel = 1'b0;
   logic                       step = 1'b0;
   logic                       step_dir = 1'b0;
   logic                       origin = 1'b0;
   logic                       alarm_on = 1'b0;
   logic [7:0]                 alarm_code = '0;
   logic                       store_origin = 1'b0;
   logic                       busy_o;
   logic                       msg_valid_o;
   logic                       alarm_valid_o;
   logic [7:0]                 alarm_code_o;
   logic signed [15:0]         upper_o;
   logic signed [35:0]         encoder_pos_o;
   logic signed [35:0]         machine_pos_o;
   logic                       parity_err_o;
   logic                       origin_seen_o;
   logic [7:0]                 ch;
   abs_link_pkg::char_t        exp_q[$];
   abs_link_pkg::char_t        got_q[$];
   int                         bad_count = 0;
   int                         total_checks = 0;
   int                         up, lo, dv, mag, code, n, seed_v;
   longint                     q;

   abs_link_if link();
   abs_pos_out abs_pos_out_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .sensor_on_command_i(sensor_on),
      .position_i(position), .output_divider_setting_i(divider), .direction_select_setting_i(dir_sel),
      .incr_step_i(step), .incr_dir_i(step_dir), .origin_pulse_i(origin), .alarm_active_i(alarm_on),
      .alarm_code_i(alarm_code), .busy_o(busy_o), .link(link));
   abs_pos_host abs_pos_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .store_origin_i(store_origin), .link(link),
      .msg_valid_o(msg_valid_o), .alarm_valid_o(alarm_valid_o), .alarm_code_o(alarm_code_o), .upper_o(upper_o),
      .encoder_pos_o(encoder_pos_o), .machine_pos_o(machine_pos_o), .parity_err_o(parity_err_o),
      .origin_seen_o(origin_seen_o));
   abs_link_assertions abs_link_assertions_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
      .phase_a_divided_out(link.phase_a_divided_out), .phase_b_divided_out(link.phase_b_divided_out),
      .origin_marker_out(link.origin_marker_out));

   // ----------------------------------------
   // clock, watchdog, shared tasks
   // ----------------------------------------
   initial begin
      forever #25 clk_i = ~clk_i;
   end

   initial begin
      repeat (420000) @(posedge clk_i);
      bad_count++;
      final_report();
   end

   task automatic check(string what, logic [63:0] exp, logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // wire monitor: decodes every frame on phase a
   // ----------------------------------------
   initial begin
      forever begin
         @(negedge link.phase_a_divided_out);
         if (!link.phase_b_divided_out) begin
            repeat (BITC / 2) @(negedge clk_i);
            check("start bit", 0, link.phase_a_divided_out);
            for (int k = 0; k < 8; k++) begin
               repeat (BITC) @(negedge clk_i);
               ch[k] = link.phase_a_divided_out;
            end
            check("parity", 0, ^ch);
            got_q.push_back(ch[6:0]);
            repeat (BITC) @(negedge clk_i);
            check("stop bit", 1, link.phase_a_divided_out);
         end
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed_v = $urandom(32'h6445);
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      up = -int'($urandom_range(2000, 1));
      lo = $urandom_range(40, 1);
      dv = $urandom_range(4, 1);
      q = longint'(up) * 1048576 + lo;
      mag = -up;
      exp_q.push_back(`CH_P);
      exp_q.push_back(`CH_MINUS);
      for (int d = 10000; d > 0; d = d / 10) exp_q.push_back(`CH_ZERO + 7'((mag / d) % 10));
      exp_q.push_back(`CH_CR);
      @(posedge clk_i);
      position <= 36'(q * dv);
      divider <= 16'(dv);
      sensor_on <= 1'b1;
      origin <= 1'b1;
      repeat (6) @(negedge clk_i);
      check("origin seen", 1, origin_seen_o);
      n = 0;
      while (msg_valid_o !== 1'b1 && n < 200000) begin
         @(negedge clk_i);
         n++;
      end
      check("upper", 64'(up), upper_o);
      check("origin during message", 1, origin_seen_o);
      n = 0;
      while (busy_o !== 1'b0 && n < 20000) begin
         @(negedge clk_i);
         n++;
      end
      check("encoder position", 64'(q), encoder_pos_o);
      @(posedge clk_i);
      store_origin <= 1'b1;
      origin <= 1'b0;
      @(posedge clk_i);
      store_origin <= 1'b0;
      repeat (4) @(negedge clk_i);
      check("machine at origin", 0, machine_pos_o);
      // four plain forward steps, then four reverse steps turned forward again by the direction select
      for (int s = 0; s < 8; s++) begin
         @(posedge clk_i);
         step_dir <= (s >= 4);
         dir_sel <= (s >= 4);
         step <= 1'b1;
         @(posedge clk_i);
         step <= 1'b0;
         repeat (80) @(posedge clk_i);
      end
      @(negedge clk_i);
      check("incremental count", 64'(q + 8), encoder_pos_o);
      check("machine position", 8, machine_pos_o);
      code = $urandom_range(99, 0);
      exp_q.push_back(`CH_A);
      exp_q.push_back(`CH_M);
      exp_q.push_back(`CH_ZERO + 7'(code / 10));
      exp_q.push_back(`CH_ZERO + 7'(code % 10));
      exp_q.push_back(`CH_CR);
      @(posedge clk_i);
      alarm_code <= 8'(code);
      alarm_on <= 1'b1;
      sensor_on <= 1'b0;
      n = 0;
      while (alarm_valid_o !== 1'b1 && n < 120000) begin
         @(negedge clk_i);
         n++;
      end
      repeat (BITC) @(negedge clk_i);
      check("alarm code", 64'(code), alarm_code_o);
      check("parity error", 0, parity_err_o);
      check("char count", exp_q.size(), got_q.size());
      for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) check("char", exp_q[i], got_q[i]);
      final_report();
   end
endmodule
